//--- dv/drive_bus_model.sv
// Model of the polled RS-485 drives and of their reaction to a stopped fieldbus master
`timescale 1ns/10ps
module drive_bus_model
    import alarm_warning_pkg::*;
#(
    parameter int unsigned POLL_CYC = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic poll_halt_i,
    input wire logic err_mode_i,
    input wire logic silent_i,
    input wire logic alarm_flag_i,
    input wire logic master_stopped_i,
    input wire logic motor_run_i,
    input wire logic drive_reset_i,
    output logic comm_error_o,
    output logic comm_timeout_o,
    output logic frame_done_o,
    output logic poll_o,
    output logic conv_alarm_o,
    output logic net_alarm_o
);
    int unsigned cnt;
    logic poll_now;
    // A halted converter sends no polls, so no replies arrive
    assign poll_now = (cnt == POLL_CYC - 1) && !poll_halt_i;
    assign conv_alarm_o = alarm_flag_i;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 0;
            poll_o <= 1'b0;
            frame_done_o <= 1'b0;
            comm_error_o <= 1'b0;
            comm_timeout_o <= 1'b0;
            net_alarm_o <= 1'b0;
        end else begin
            cnt <= (cnt == POLL_CYC - 1) ? 0 : cnt + 1;
            poll_o <= poll_now;
            frame_done_o <= poll_now && !silent_i;
            comm_error_o <= poll_now && err_mode_i && !silent_i;
            comm_timeout_o <= poll_now && silent_i;
            if (drive_reset_i) begin
                net_alarm_o <= 1'b0;
            end else if (master_stopped_i && motor_run_i) begin
                net_alarm_o <= 1'b1;
            end
        end
    end
endmodule // drive_bus_model

//--- dv/tb_top.sv
// Self-checking testbench of the alarm and warning manager
`timescale 1ns/10ps
module tb_top;
    import alarm_warning_pkg::*;
    logic clk_sys_i = 0, rst_i = 1, cpu_fault = 0, nv_corrupt = 0;
    logic rst_cmd = 0, ahc = 0, whc = 0, master_stopped = 0;
    logic link_up = 0, link_traffic = 0, err_mode = 0, silent = 0;
    logic motor_run = 0, drive_reset = 0;
    logic [3:0] rate = 4'h7, hidx = 4'h0;
    logic [2:0] err_pat = 3'h0;
    bus_state_type bus_state = BUS_INIT;
    logic alarm_flag, warning_flag, alarm_lamp, state_lamp, error_lamp;
    logic link_lamp, poll_halt, motor_stop, m_err, m_to, m_done, poll;
    logic conv_alarm, net_alarm;
    logic [7:0] alarm_code, warning_code, alarm_hist, warning_hist;
    fault_in_type faults;
    int n_errors = 0, checks_done = 0, n, g;
    logic [7:0] ah, wh;
    assign faults = '{cpu_fault, nv_corrupt, m_err, m_to, m_done};
    always #4 clk_sys_i = ~clk_sys_i;

    alarm_warning_manager #(.HALF_CYC(4), .FLICK_CYC(2)) dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .fault_i(faults),
        .rate_select_switch_i(rate), .alarm_reset_cmd_i(rst_cmd),
        .alarm_hist_clear_i(ahc), .warn_hist_clear_i(whc),
        .hist_index_i(hidx), .bus_state_i(bus_state),
        .bus_error_pat_i(err_pat), .master_stopped_i(master_stopped),
        .link_up_i(link_up), .link_traffic_i(link_traffic),
        .alarm_flag_o(alarm_flag), .warning_flag_o(warning_flag),
        .alarm_code_o(alarm_code), .warning_code_o(warning_code),
        .alarm_hist_o(alarm_hist), .warning_hist_o(warning_hist),
        .alarm_lamp_o(alarm_lamp), .state_lamp_o(state_lamp),
        .error_lamp_o(error_lamp), .link_lamp_o(link_lamp),
        .poll_halt_o(poll_halt), .motor_stop_o(motor_stop));

    drive_bus_model #(.POLL_CYC(8)) partner (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .poll_halt_i(poll_halt),
        .err_mode_i(err_mode), .silent_i(silent),
        .alarm_flag_i(alarm_flag), .master_stopped_i(master_stopped),
        .motor_run_i(motor_run), .drive_reset_i(drive_reset),
        .comm_error_o(m_err), .comm_timeout_o(m_to),
        .frame_done_o(m_done), .poll_o(poll),
        .conv_alarm_o(conv_alarm), .net_alarm_o(net_alarm));

    // ==========================================================
    // Access and compare tasks
    task automatic step(input int c);
        repeat (c) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic chk_cnt(input int got, input int exp);
        chk8(got[7:0], exp[7:0]);
    endtask
    // Waits for a fresh poll; two cycles later its one-cycle effect shows
    task automatic do_poll(input logic e, input logic s);
        int k;
        err_mode = e;
        silent = s;
        step(1);
        for (k = 0; k < 50 && poll !== 1'b1; k++) step(1);
        chk1(poll, 1'b1);
        err_mode = 0;
        silent = 0;
        step(2);
    endtask
    // Syncs to a dark gap first, so a half-seen group is never counted
    task automatic count_blinks(output int b, output int g);
        int k, quiet;
        logic prev;
        b = 0;
        quiet = 0;
        prev = 1'b0;
        for (k = 0; k < 400 && quiet < 10; k++) begin
            step(1);
            quiet = alarm_lamp ? 0 : quiet + 1;
        end
        quiet = 0;
        for (k = 0; k < 400 && !(quiet >= 10 && b > 0); k++) begin
            step(1);
            if (alarm_lamp && !prev) b++;
            prev = alarm_lamp;
            quiet = alarm_lamp ? 0 : quiet + 1;
        end
        for (k = 0; k < 400 && !alarm_lamp; k++) begin
            step(1);
            if (!alarm_lamp) quiet++;
        end
        g = quiet;
    endtask
    // Rising edges of one lamp over two full 32-cycle frames
    task automatic count_rises(input int which, output int r);
        logic cur, prev;
        r = 0;
        step(3);
        prev = (which == 0) ? state_lamp :
               (which == 1) ? error_lamp : link_lamp;
        repeat (64) begin
            step(1);
            cur = (which == 0) ? state_lamp :
                  (which == 1) ? error_lamp : link_lamp;
            if (cur && !prev) r++;
            prev = cur;
        end
    endtask
    task automatic read_hist(input logic [3:0] i);
        hidx = i;
        step(3);
        ah = alarm_hist;
        wh = warning_hist;
    endtask
    task automatic pulse_reset_cmd;
        rst_cmd = 1;
        step(1);
        rst_cmd = 0;
        step(3);
    endtask
    task automatic give_verdict;
        $display("Errors %0d, checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #(8 * 20000);
        n_errors++;
        give_verdict();
    end

    // ==========================================================
    // Test sequence
    initial begin
        step(20);
        rst_i = 0;
        step(3);
        chk1(alarm_flag, 1'b0);
        // Fieldbus lamps: state, error and link patterns
        bus_state = BUS_PREOP;
        count_rises(0, n); chk_cnt(n, 8);
        bus_state = BUS_SAFEOP;
        count_rises(0, n); chk_cnt(n, 2);
        bus_state = BUS_OP;
        count_rises(0, n); chk1(state_lamp, 1'b1);
        for (int p = 0; p < 4; p++) begin
            err_pat = p[2:0];
            count_rises(1, n);
            chk_cnt(n, (p == 1) ? 8 : (p == 0) ? 0 : 2 * p - 2);
            chk1(motor_stop, p != 0);
        end
        err_pat = 3'h0;
        step(1); chk1(link_lamp, 1'b0);
        link_up = 1;
        step(3); chk1(link_lamp, 1'b1);
        link_traffic = 1;
        count_rises(2, n); chk1(n > 4, 1'b1);
        motor_run = 1;
        master_stopped = 1;
        step(3); chk1(motor_stop, 1'b1);
        chk1(net_alarm, 1'b1); chk1(alarm_flag, 1'b0);
        master_stopped = 0;
        drive_reset = 1;
        step(1);
        drive_reset = 0;
        // Rate switch off 7 is raised again right after a reset command
        rate = 4'h3;
        step(3); chk8(alarm_code, CODE_SWITCH);
        chk1(alarm_flag, 1'b1); chk1(conv_alarm, 1'b1);
        chk1(poll_halt, 1'b1);
        count_blinks(n, g); chk_cnt(n, 7);
        chk_cnt(g, (GROUP_GAP_HALVES + 1) * 4);
        pulse_reset_cmd(); chk8(alarm_code, CODE_SWITCH);
        rate = 4'h7;
        pulse_reset_cmd(); chk1(alarm_flag, 1'b0);
        // One bad poll warns, a good one clears, three in a row alarm
        do_poll(1, 0); chk8(warning_code, WCODE_COMM);
        chk1(warning_flag, 1'b1); chk1(alarm_flag, 1'b0);
        do_poll(0, 0); chk1(warning_flag, 1'b0);
        repeat (3) do_poll(1, 0);
        chk8(alarm_code, CODE_COMM); chk1(poll_halt, 1'b1);
        count_blinks(n, g); chk_cnt(n, 7);
        pulse_reset_cmd(); chk1(alarm_flag, 1'b0);
        do_poll(0, 1); chk8(warning_code, WCODE_TIMEOUT);
        do_poll(0, 0);
        // Corrupted stored data keeps polling alive
        nv_corrupt = 1;
        step(3); chk8(alarm_code, CODE_NVDATA);
        chk1(poll_halt, 1'b0);
        count_blinks(n, g); chk_cnt(n, 9);
        nv_corrupt = 0;
        pulse_reset_cmd();
        read_hist(4'h0); chk8(ah, CODE_NVDATA); chk8(wh, WCODE_TIMEOUT);
        read_hist(4'h1); chk8(ah, CODE_COMM); chk8(wh, WCODE_COMM);
        read_hist(4'h2); chk8(ah, CODE_SWITCH);
        read_hist(4'hA); chk8(ah, CODE_NONE);
        ahc = 1;
        whc = 1;
        step(1);
        ahc = 0;
        whc = 0;
        read_hist(4'h0); chk8(ah, CODE_NONE); chk8(wh, CODE_NONE);
        // Processor fault: steady lamp, overrides, only a power cycle
        cpu_fault = 1;
        rate = 4'h2;
        step(3); chk8(alarm_code, CODE_CPU);
        n = 0;
        repeat (40) begin
            step(1);
            if (alarm_lamp !== 1'b1) n++;
        end
        chk_cnt(n, 0);
        pulse_reset_cmd(); chk8(alarm_code, CODE_CPU);
        cpu_fault = 0;
        rate = 4'h7;
        rst_i = 1;
        step(2);
        rst_i = 0;
        step(3); chk1(alarm_flag, 1'b0);
        give_verdict();
    end
endmodule // tb_top

//--- src/alarm_warning_manager.sv
// Alarm, warning, history and lamp logic of the network converter
`timescale 1ns/10ps
// Operation
// - Any alarm sets flag; all but processor fault start blinking
// - Blink count per alarm, 200 ms halves
// - Ten newest alarm codes, readable, clearable
// - Reset command or power cycle clears alarm
// - Processor fault lamp steady, power only
// - Rate switch not 7 raises 83h
// - Three consecutive serial errors raise 84h
// - Corrupted stored data raises 41h
// - Any alarm but 41h halts RS-485 polling
// - Fieldbus error or master stop halts motors
// - State and error lamp patterns
// - Link lamp off, lit, flickering
// - Warning flag, self clears when cause gone
// - Ten newest warning codes, readable, clearable
// - Single serial error raises warning 84h
// - Incomplete response frame raises warning 85h
module alarm_warning_manager
    import alarm_warning_pkg::*;
#(
    parameter int unsigned HALF_CYC = BLINK_HALF_CYC,
    parameter int unsigned FLICK_CYC = FLICKER_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire fault_in_type fault_i,
    input wire logic [3:0] rate_select_switch_i,
    input wire logic alarm_reset_cmd_i,
    input wire logic alarm_hist_clear_i,
    input wire logic warn_hist_clear_i,
    input wire logic [3:0] hist_index_i,
    input wire bus_state_type bus_state_i,
    input wire logic [2:0] bus_error_pat_i,
    input wire logic master_stopped_i,
    input wire logic link_up_i,
    input wire logic link_traffic_i,
    output logic alarm_flag_o,
    output logic warning_flag_o,
    output logic [7:0] alarm_code_o,
    output logic [7:0] warning_code_o,
    output logic [7:0] alarm_hist_o,
    output logic [7:0] warning_hist_o,
    output logic alarm_lamp_o,
    output logic state_lamp_o,
    output logic error_lamp_o,
    output logic link_lamp_o,
    output logic poll_halt_o,
    output logic motor_stop_o
);
    // ==========================================================
    // Alarm capture
    logic [7:0] alarm_code, next_alarm_code;
    logic [3:0] blinks, next_blinks;
    logic [1:0] err_run, next_err_run;
    logic [7:0] wcode, next_wcode;
    logic [7:0] ahist [HIST_DEPTH];
    logic [7:0] whist [HIST_DEPTH];
    logic apush, wpush;
    always_comb begin
        next_alarm_code = alarm_code;
        next_blinks = blinks;
        next_err_run = err_run;
        apush = 1'b0;
        if (fault_i.comm_error && err_run != 2'(COMM_ERR_LIMIT)) begin
            next_err_run = err_run + 2'h1;
        end else if (!fault_i.comm_error && fault_i.frame_done) begin
            next_err_run = 2'h0;
        end
        if (alarm_reset_cmd_i && alarm_code != CODE_CPU) begin
            next_alarm_code = CODE_NONE;
            next_blinks = 4'h0;
            next_err_run = 2'h0;
        end
        if (fault_i.cpu_fault && alarm_code != CODE_CPU) begin
            next_alarm_code = CODE_CPU;
            next_blinks = 4'h0;
            apush = 1'b1;
        end else if (alarm_code == CODE_NONE) begin
            if (fault_i.nv_corrupt) begin
                next_alarm_code = CODE_NVDATA;
                next_blinks = BLINKS_NVDATA;
                apush = 1'b1;
            end else if (rate_select_switch_i != RATE_OK) begin
                next_alarm_code = CODE_SWITCH;
                next_blinks = BLINKS_SWITCH;
                apush = 1'b1;
            end else if (fault_i.comm_error &&
                         err_run == 2'(COMM_ERR_LIMIT - 1)) begin
                next_alarm_code = CODE_COMM;
                next_blinks = BLINKS_COMM;
                apush = 1'b1;
            end
        end
        next_wcode = fault_i.comm_error ? WCODE_COMM :
                     fault_i.comm_timeout ? WCODE_TIMEOUT : CODE_NONE;
        wpush = (next_wcode != CODE_NONE) && (next_wcode != wcode);
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            alarm_code <= CODE_NONE;
            blinks <= 4'h0;
            err_run <= 2'h0;
            wcode <= CODE_NONE;
        end else begin
            alarm_code <= next_alarm_code;
            blinks <= next_blinks;
            err_run <= next_err_run;
            wcode <= next_wcode;
        end
    end
    // ==========================================================
    // Histories, newest in entry 0
    // Push in the clear cycle survives, so no event is lost
    genvar gi;
    generate
        for (gi = 0; gi < HIST_DEPTH; gi++) begin : g_hist
            localparam int PREV = (gi == 0) ? 0 : gi - 1;
            logic [7:0] next_a, next_w;
            always_comb begin
                next_a = (apush && gi == 0) ? next_alarm_code :
                         alarm_hist_clear_i ? CODE_NONE :
                         apush ? ahist[PREV] : ahist[gi];
                next_w = (wpush && gi == 0) ? next_wcode :
                         warn_hist_clear_i ? CODE_NONE :
                         wpush ? whist[PREV] : whist[gi];
            end
            always_ff @(posedge clk_sys_i or posedge rst_i) begin
                if (rst_i) begin
                    ahist[gi] <= CODE_NONE;
                    whist[gi] <= CODE_NONE;
                end else begin
                    ahist[gi] <= next_a;
                    whist[gi] <= next_w;
                end
            end
        end
    endgenerate
    // ==========================================================
    // Alarm lamp sequencer
    lamp_state_type lamp_st, next_lamp_st;
    logic [31:0] tick, next_tick;
    logic [4:0] halves, next_halves, last_half;
    logic half_done;
    assign half_done = (tick == 32'(HALF_CYC - 1));
    assign last_half = (lamp_st == LAMP_ON) ? 5'({blinks, 1'b0} - 5'h01) :
                       5'(GROUP_GAP_HALVES - 1);
    always_comb begin
        next_lamp_st = lamp_st;
        next_tick = half_done ? 32'h0000_0000 : tick + 32'h0000_0001;
        next_halves = halves;
        unique case (lamp_st)
            LAMP_IDLE: begin
                next_tick = 32'h0000_0000;
                next_halves = 5'h00;
                if (alarm_code != CODE_NONE && alarm_code != CODE_CPU) begin
                    next_lamp_st = LAMP_ON;
                end
            end
            LAMP_ON, LAMP_GAP: begin
                if (alarm_code == CODE_NONE || alarm_code == CODE_CPU) begin
                    next_lamp_st = LAMP_IDLE;
                end else if (half_done) begin
                    next_halves = halves + 5'h01;
                    if (halves == last_half) begin
                        next_halves = 5'h00;
                        next_lamp_st = (lamp_st == LAMP_ON) ? LAMP_GAP :
                                       LAMP_ON;
                    end
                end
            end
        endcase
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lamp_st <= LAMP_IDLE;
            tick <= 32'h0000_0000;
            halves <= 5'h00;
        end else begin
            lamp_st <= next_lamp_st;
            tick <= next_tick;
            halves <= next_halves;
        end
    end
    // ==========================================================
    // Fieldbus lamps: 8-slot frame of 200 ms slots
    logic [2:0] slot, next_slot;
    logic [31:0] ftick, next_ftick, stick, next_stick;
    logic flick, next_flick, slot_done;
    // Own slot timer: the alarm timer rests while no alarm is up
    assign slot_done = (stick == 32'(HALF_CYC - 1));
    function automatic logic pat_level(input logic [2:0] pat,
                                       input logic [2:0] s);
        unique case (pat)
            PAT_OFF: pat_level = 1'b0;
            PAT_BLINK: pat_level = ~s[0];
            PAT_SINGLE: pat_level = (s == 3'h0);
            PAT_DOUBLE: pat_level = (s == 3'h0) || (s == 3'h2);
            PAT_ON: pat_level = 1'b1;
            default: pat_level = 1'b0;
        endcase
    endfunction
    always_comb begin
        next_stick = slot_done ? 32'h0000_0000 : stick + 32'h0000_0001;
        next_slot = slot_done ? slot + 3'h1 : slot;
        next_ftick = (ftick == 32'(FLICK_CYC - 1)) ? 32'h0000_0000 :
                     ftick + 32'h0000_0001;
        next_flick = (ftick == 32'(FLICK_CYC - 1)) ? ~flick : flick;
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            slot <= 3'h0;
            stick <= 32'h0000_0000;
            ftick <= 32'h0000_0000;
            flick <= 1'b0;
        end else begin
            slot <= next_slot;
            stick <= next_stick;
            ftick <= next_ftick;
            flick <= next_flick;
        end
    end
    // ==========================================================
    // Registered outputs
    logic [2:0] st_pat;
    always_comb begin
        unique case (bus_state_i)
            BUS_INIT: st_pat = PAT_OFF;
            BUS_PREOP: st_pat = PAT_BLINK;
            BUS_SAFEOP: st_pat = PAT_SINGLE;
            BUS_OP: st_pat = PAT_ON;
            default: st_pat = PAT_OFF;
        endcase
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            alarm_flag_o <= 1'b0;
            warning_flag_o <= 1'b0;
            alarm_code_o <= CODE_NONE;
            warning_code_o <= CODE_NONE;
            alarm_hist_o <= CODE_NONE;
            warning_hist_o <= CODE_NONE;
            alarm_lamp_o <= 1'b0;
            state_lamp_o <= 1'b0;
            error_lamp_o <= 1'b0;
            link_lamp_o <= 1'b0;
            poll_halt_o <= 1'b0;
            motor_stop_o <= 1'b0;
        end else begin
            alarm_flag_o <= (alarm_code != CODE_NONE);
            warning_flag_o <= (wcode != CODE_NONE);
            alarm_code_o <= alarm_code;
            warning_code_o <= wcode;
            alarm_hist_o <= (hist_index_i < 4'(HIST_DEPTH)) ?
                            ahist[hist_index_i] : CODE_NONE;
            warning_hist_o <= (hist_index_i < 4'(HIST_DEPTH)) ?
                              whist[hist_index_i] : CODE_NONE;
            alarm_lamp_o <= (alarm_code == CODE_CPU) ||
                            (lamp_st == LAMP_ON && !halves[0]);
            state_lamp_o <= pat_level(st_pat, slot);
            error_lamp_o <= pat_level(bus_error_pat_i, slot);
            link_lamp_o <= link_up_i && (!link_traffic_i || flick);
            poll_halt_o <= (alarm_code != CODE_NONE) &&
                           (alarm_code != CODE_NVDATA);
            motor_stop_o <= (bus_error_pat_i != PAT_OFF) || master_stopped_i;
        end
    end
    // ==========================================================
    // Checks
    sequence s_third_err;
        fault_i.comm_error && err_run == 2'h2 && alarm_code == CODE_NONE &&
        !fault_i.cpu_fault && !fault_i.nv_corrupt &&
        rate_select_switch_i == RATE_OK && !alarm_reset_cmd_i;
    endsequence
    chk_serial_alarm_raise: assert property (@(posedge clk_sys_i)
        disable iff (rst_i) s_third_err |=> alarm_code == CODE_COMM)
        else $error("serial alarm not raised");
    chk_alarm_flag_set: assert property (@(posedge clk_sys_i)
        disable iff (rst_i) alarm_code != CODE_NONE |=> alarm_flag_o)
        else $error("alarm flag missing");
    chk_cpu_sticky: assert property (@(posedge clk_sys_i)
        disable iff (rst_i) alarm_code == CODE_CPU |=> alarm_code == CODE_CPU)
        else $error("processor fault cleared");
    chk_cpu_lamp: assert property (@(posedge clk_sys_i)
        disable iff (rst_i) alarm_code == CODE_CPU |=> alarm_lamp_o)
        else $error("processor lamp not steady");
    chk_reset_cmd: assert property (@(posedge clk_sys_i)
        disable iff (rst_i) alarm_reset_cmd_i && alarm_code != CODE_CPU &&
        !fault_i.cpu_fault && !fault_i.nv_corrupt &&
        rate_select_switch_i == RATE_OK && !fault_i.comm_error
        |=> alarm_code == CODE_NONE)
        else $error("reset command ignored");
    chk_switch_alarm: assert property (@(posedge clk_sys_i)
        disable iff (rst_i) alarm_code == CODE_NONE && !fault_i.cpu_fault &&
        !fault_i.nv_corrupt && rate_select_switch_i != RATE_OK
        |=> alarm_code == CODE_SWITCH && blinks == BLINKS_SWITCH)
        else $error("switch alarm missing");
    chk_nv_alarm: assert property (@(posedge clk_sys_i)
        disable iff (rst_i) alarm_code == CODE_NONE && !fault_i.cpu_fault &&
        fault_i.nv_corrupt |=> alarm_code == CODE_NVDATA && blinks == 4'h9)
        else $error("stored data alarm missing");
    chk_warning_clear: assert property (@(posedge clk_sys_i)
        disable iff (rst_i) !fault_i.comm_error && !fault_i.comm_timeout
        |=> ##1 !warning_flag_o)
        else $error("warning did not self clear");
    chk_timeout_warn: assert property (@(posedge clk_sys_i)
        disable iff (rst_i) !fault_i.comm_error && fault_i.comm_timeout
        |=> wcode == WCODE_TIMEOUT)
        else $error("timeout warning missing");
    chk_hist_push: assert property (@(posedge clk_sys_i)
        disable iff (rst_i) apush |=> ahist[0] == $past(next_alarm_code))
        else $error("alarm history not updated");
    chk_motor_stop: assert property (@(posedge clk_sys_i)
        disable iff (rst_i) master_stopped_i |=> motor_stop_o)
        else $error("motor not stopped");
endmodule // alarm_warning_manager

//--- src/alarm_warning_pkg.sv
// Constants and carrier types of the alarm and warning manager
package alarm_warning_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned BLINK_HALF_MS = 200;
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int unsigned GROUP_GAP_HALVES = 6;
    localparam int unsigned FLASH_MS = 200;
    localparam int unsigned FLICKER_MS = 50;
    localparam int unsigned FLICKER_CYC = CLK_HZ / 1000 * FLICKER_MS;
    localparam int unsigned HIST_DEPTH = 10;
    localparam int unsigned COMM_ERR_LIMIT = 3;
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_SWITCH = 8'h83;
    localparam logic [7:0] CODE_COMM = 8'h84;
    localparam logic [7:0] CODE_NVDATA = 8'h41;
    localparam logic [7:0] CODE_CPU = 8'hF0;
    localparam logic [7:0] WCODE_COMM = 8'h84;
    localparam logic [7:0] WCODE_TIMEOUT = 8'h85;
    localparam logic [3:0] RATE_OK = 4'h7;
    localparam logic [3:0] BLINKS_SWITCH = 4'h7;
    localparam logic [3:0] BLINKS_COMM = 4'h7;
    localparam logic [3:0] BLINKS_NVDATA = 4'h9;
    localparam logic [2:0] PAT_OFF = 3'h0;
    localparam logic [2:0] PAT_BLINK = 3'h1;
    localparam logic [2:0] PAT_SINGLE = 3'h2;
    localparam logic [2:0] PAT_DOUBLE = 3'h3;
    localparam logic [2:0] PAT_ON = 3'h4;
    typedef enum logic [3:0] {
        BUS_INIT = 4'b0001,
        BUS_PREOP = 4'b0010,
        BUS_SAFEOP = 4'b0100,
        BUS_OP = 4'b1000
    } bus_state_type;
    typedef enum logic [2:0] {
        LAMP_IDLE = 3'b001,
        LAMP_ON = 3'b010,
        LAMP_GAP = 3'b100
    } lamp_state_type;
    typedef struct packed {
        logic cpu_fault;
        logic nv_corrupt;
        logic comm_error;
        logic comm_timeout;
        logic frame_done;
    } fault_in_type;
endpackage
